// ---- rtl/wdt_pkg.sv ----
// Constants, register map and field layout of the watchdog reset timer.
// Notes on behaviour
// - Six-bit watchdog counter advanced by the thirteen-bit prescaler, both on the oscillator clock.
// - Uncleared watchdog overflows after 2^18 minus 2^4 cycles and requests system reset.
// - A write to the clear address clears the watchdog and restarts the timeout, except in a cycle with a vector fetch, stop entry or power-on clear.
// - Each clear write also zeroes prescaler bits twelve to four, keeping bits three to zero.
// - Reading the clear address returns the reset vector low byte, counter undisturbed.
// - Watchdog reset drives the reset pin low 32 cycles and sets the cause bit.
// - Power-on logic clears the prescaler 4096 cycles after power is applied.
// - Any internal reset clears both prescaler and watchdog counter.
// - A reset vector fetch clears the prescaler.
// - The disable output follows the disable bit of the write-once configuration register.
// - Disable bit one disables, zero enables; it reads zero after reset.
// - Monitor mode with test high voltage on interrupt or reset pin disables the watchdog.
// - The watchdog keeps counting and can reset the device during wait mode.
// - Entering stop mode freezes the watchdog clock and clears the prescaler.
// - The watchdog never raises an interrupt; timeout only causes system reset.
// - Watchdog and prescaler run on the undivided crystal oscillator clock.
package wdt_pkg;

    localparam int unsigned WDT_ADDR_W = 16;
    localparam int unsigned WDT_DATA_W = 8;

    localparam logic [15:0] WDT_ADDR_CLEAR = 16'hFFFF;
    localparam logic [15:0] WDT_ADDR_CONFIG = 16'h001F;
    localparam logic [15:0] WDT_ADDR_CAUSE = 16'h0F01;

    localparam int unsigned WDT_CFG_DISABLE_BIT = 0;
    localparam logic WDT_CFG_DISABLE_RST = 1'b0;
    localparam int unsigned WDT_CAUSE_WDOG_BIT = 4;

    localparam int unsigned WDT_PRESC_W = 13;
    localparam int unsigned WDT_WDOG_W = 6;
    localparam int unsigned WDT_PRESC_KEEP_LSBS = 4;

    localparam int unsigned WDT_TIMEOUT_CYC = (2 ** 18) - (2 ** 4);
    localparam int unsigned WDT_PIN_LOW_CYC = 32;
    localparam int unsigned WDT_POR_CLEAR_CYC = 4096;

    localparam logic [7:0] WDT_READ_ZERO = 8'h00;

endpackage

// ---- rtl/wdt_pulse_stretch.sv ----
// Stretches a one-cycle trigger into an active window of a fixed number of cycles.
`timescale 1ns/100ps
module wdt_pulse_stretch #(
    parameter int unsigned LEN = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic trigger,
    output logic active
);

    localparam int unsigned CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);

    logic [CW-1:0] left_q;
    logic [CW-1:0] left_d;

    initial begin
        if (LEN < 1) begin
            $error("wdt_pulse_stretch needs LEN of at least one");
        end
    end

    // A trigger inside a running window restarts it, so the pin never shortens.
    always_comb begin
        left_d = left_q;
        if (trigger) begin
            left_d = LEN_C;
        end else if (left_q != '0) begin
            left_d = left_q - CW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            left_q <= '0;
        end else begin
            left_q <= left_d;
        end
    end

    assign active = (left_q != '0);

endmodule // wdt_pulse_stretch

// ---- rtl/wdt_reset_timer.sv ----
// Watchdog reset timer: prescaler, watchdog counter, register port and reset pin drive.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module wdt_reset_timer
    import wdt_pkg::*;
#(
    parameter int unsigned PRESC_W = WDT_PRESC_W,
    parameter int unsigned WDOG_W = WDT_WDOG_W,
    parameter int unsigned TIMEOUT_CYCLES = WDT_TIMEOUT_CYC,
    parameter int unsigned PIN_LOW_CYCLES = WDT_PIN_LOW_CYC,
    parameter int unsigned POR_CLEAR_CYCLES = WDT_POR_CLEAR_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WDT_ADDR_W-1:0] bus_addr,
    input wire logic [WDT_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [WDT_DATA_W-1:0] bus_rdata,
    input wire logic [WDT_DATA_W-1:0] reset_vector_low,
    input wire logic internal_reset,
    input wire logic vector_fetch,
    input wire logic stop_mode,
    input wire logic monitor_mode,
    input wire logic irq_test_high_voltage,
    input wire logic rst_test_high_voltage,
    output logic watchdog_disable,
    output logic sys_reset_req,
    output logic rst_pin_out,
    output logic rst_pin_oe
);

    // Combined count: watchdog counter on top of the prescaler bits below its tap.
    localparam int unsigned LOW_W = PRESC_W - 1;
    localparam int unsigned CNT_W = WDOG_W + LOW_W;
    localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(TIMEOUT_CYCLES - 1);
    localparam int unsigned POR_W = $clog2(POR_CLEAR_CYCLES + 1);
    localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CLEAR_CYCLES - 1);

    typedef enum logic [1:0] {
        WDT_POR_WAIT,
        WDT_POR_DONE
    } wdt_por_state_t;

    initial begin
        if (PRESC_W <= WDT_PRESC_KEEP_LSBS + 1 || WDOG_W < 1) begin
            $error("wdt_reset_timer counter widths too small");
        end
        if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > (2 ** CNT_W)) begin
            $error("wdt_reset_timer timeout does not fit the counters");
        end
        if (PIN_LOW_CYCLES < 1 || POR_CLEAR_CYCLES < 1) begin
            $error("wdt_reset_timer pulse lengths must be at least one");
        end
        // A clear keeps up to fifteen prescaler counts, so a shorter timeout could fire at once.
        if (TIMEOUT_CYCLES <= (2 ** WDT_PRESC_KEEP_LSBS)) begin
            $error("wdt_reset_timer timeout shorter than the kept prescaler bits");
        end
        if (CNT_W > 31) begin
            $error("wdt_reset_timer combined count too wide");
        end
    end

    // Pin-level test voltage detectors come from outside the clock domain.
    logic [1:0] vhi_s;
    wdt_sync2 #(
        .W(2)
    ) u_vhi_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({irq_test_high_voltage, rst_test_high_voltage}),
        .sync_out(vhi_s)
    );

    // The stretcher owns the pin window, so a request can never be cut short by new events.
    logic pin_low_active;
    logic overflow;
    wdt_pulse_stretch #(
        .LEN(PIN_LOW_CYCLES)
    ) u_pin_stretch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .trigger(overflow),
        .active(pin_low_active)
    );

    // Bus decode. Only the full sixteen-bit address matches, so aliases never clear the timer.
    logic clear_wr;
    logic config_wr;
    assign clear_wr = bus_wr && (bus_addr == WDT_ADDR_CLEAR);
    assign config_wr = bus_wr && (bus_addr == WDT_ADDR_CONFIG);

    // Power-on clear of the prescaler. It is a one-shot: after it fires the state machine
    // parks in its done state until the next power-on reset, so later internal resets
    // do not repeat it.
    wdt_por_state_t por_state_q;
    wdt_por_state_t por_state_d;
    logic [POR_W-1:0] por_cnt_q;
    logic [POR_W-1:0] por_cnt_d;
    logic por_clear;

    always_comb begin
        por_state_d = por_state_q;
        por_cnt_d = por_cnt_q;
        por_clear = 1'b0;
        case (por_state_q)
            WDT_POR_WAIT: begin
                if (por_cnt_q == POR_LAST) begin
                    por_clear = 1'b1;
                    por_state_d = WDT_POR_DONE;
                end else begin
                    por_cnt_d = por_cnt_q + POR_W'(1);
                end
            end
            WDT_POR_DONE: begin
                por_state_d = WDT_POR_DONE;
            end
            default: begin
                por_state_d = WDT_POR_DONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            por_state_q <= WDT_POR_WAIT;
            por_cnt_q <= '0;
        end else begin
            por_state_q <= por_state_d;
            por_cnt_q <= por_cnt_d;
        end
    end

    // Write-once configuration latch holding the disable bit. Software gets one chance
    // after every reset; a runaway program cannot later switch the watchdog off.
    logic cfg_disable_q;
    logic cfg_disable_d;
    logic cfg_written_q;
    logic cfg_written_d;
    logic any_internal_reset;

    // A watchdog reset is itself an internal reset of the device.
    assign any_internal_reset = internal_reset || pin_low_active;

    always_comb begin
        cfg_disable_d = cfg_disable_q;
        cfg_written_d = cfg_written_q;
        if (any_internal_reset) begin
            cfg_disable_d = WDT_CFG_DISABLE_RST;
            cfg_written_d = 1'b0;
        end else if (config_wr && !cfg_written_q) begin
            cfg_disable_d = bus_wdata[WDT_CFG_DISABLE_BIT];
            cfg_written_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_disable_q <= WDT_CFG_DISABLE_RST;
            cfg_written_q <= 1'b0;
        end else begin
            cfg_disable_q <= cfg_disable_d;
            cfg_written_q <= cfg_written_d;
        end
    end

    assign watchdog_disable = cfg_disable_q;

    // Counters. Both run straight off ref_clk, which is the oscillator itself.
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic [WDOG_W-1:0] wdog_q;
    logic [WDOG_W-1:0] wdog_d;
    logic stop_q;
    logic stop_d;
    logic stop_entry;
    logic wdog_inc;
    logic wdog_hold;
    logic monitor_off;
    logic count_en;
    logic tap;
    logic [CNT_W-1:0] combined;

    assign stop_entry = stop_mode && !stop_q;
    assign monitor_off = monitor_mode && (vhi_s[1] || vhi_s[0]);
    // Wait mode is deliberately absent here: the watchdog keeps running through it.
    assign count_en = !cfg_disable_q && !monitor_off && !stop_mode;
    assign tap = &presc_q[LOW_W-1:0];
    assign combined = {wdog_q, presc_q[LOW_W-1:0]};
    // Because clear writes keep the low prescaler bits, the real period can be up to
    // fifteen cycles shorter than from a full reset.
    assign overflow = count_en && !any_internal_reset && !clear_wr && (combined >= LAST_COUNT);
    // The watchdog steps only when the prescaler tap wraps; resets and clears take priority.
    assign wdog_inc = !any_internal_reset && !clear_wr && count_en && tap && !overflow;
    // Holding on overflow keeps the count still through the one-cycle request.
    assign wdog_hold = !any_internal_reset && (!count_en || overflow) && !clear_wr;

    // The prescaler keeps running while the watchdog is disabled, so enabling it later
    // does not restart the timeout; only stop mode freezes the prescaler as well.
    always_comb begin
        presc_d = presc_q;
        wdog_d = wdog_q;
        stop_d = stop_mode;
        if (any_internal_reset) begin
            presc_d = '0;
            wdog_d = '0;
        end else if (por_clear || vector_fetch || stop_entry) begin
            presc_d = '0;
        end else if (clear_wr) begin
            presc_d = {{(PRESC_W - WDT_PRESC_KEEP_LSBS){1'b0}}, presc_q[WDT_PRESC_KEEP_LSBS-1:0]};
            wdog_d = '0;
        end else if (!stop_mode) begin
            presc_d = presc_q + PRESC_W'(1);
        end
        if (wdog_inc) begin
            wdog_d = wdog_q + WDOG_W'(1);
        end
        if (wdog_hold) begin
            wdog_d = wdog_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            presc_q <= '0;
            wdog_q <= '0;
            stop_q <= 1'b0;
        end else begin
            presc_q <= presc_d;
            wdog_q <= wdog_d;
            stop_q <= stop_d;
        end
    end

    // Reset outputs. The timer has no interrupt output at all.
    logic sys_reset_q;
    logic sys_reset_d;
    logic cause_q;
    logic cause_d;

    // The cause flag survives internal resets so that software can tell why it restarted.
    always_comb begin
        sys_reset_d = overflow;
        cause_d = cause_q;
        if (overflow) begin
            cause_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sys_reset_q <= 1'b0;
            cause_q <= 1'b0;
        end else begin
            sys_reset_q <= sys_reset_d;
            cause_q <= cause_d;
        end
    end

    assign sys_reset_req = sys_reset_q;
    // The reset pin is open drain: it is only ever pulled low, the enable decides when.
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = pin_low_active;

    // Read port: data appear in the cycle after the read strobe only.
    // Reading the clear address has no side effect, so polling the vector is harmless.
    logic [WDT_DATA_W-1:0] rdata_q;
    logic [WDT_DATA_W-1:0] rdata_d;

    always_comb begin
        rdata_d = WDT_READ_ZERO;
        if (bus_rd) begin
            case (bus_addr)
                WDT_ADDR_CLEAR: begin
                    rdata_d = reset_vector_low;
                end
                WDT_ADDR_CONFIG: begin
                    rdata_d[WDT_CFG_DISABLE_BIT] = cfg_disable_q;
                end
                WDT_ADDR_CAUSE: begin
                    rdata_d[WDT_CAUSE_WDOG_BIT] = cause_q;
                end
                default: begin
                    rdata_d = WDT_READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= WDT_READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;

endmodule // wdt_reset_timer

// ---- rtl/wdt_sync2.sv ----
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/100ps
module wdt_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    initial begin
        if (W < 1) begin
            $error("wdt_sync2 needs W of at least one");
        end
    end

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // wdt_sync2

// ---- sim/wdt_reset_timer_monitor.sv ----
// Port-level assertion checker for the watchdog reset timer.
`timescale 1ns/100ps
module wdt_reset_timer_monitor
    import wdt_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = WDT_TIMEOUT_CYC,
    parameter int unsigned PIN_LOW_CYCLES = WDT_PIN_LOW_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WDT_ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [WDT_DATA_W-1:0] bus_rdata,
    input wire logic [WDT_DATA_W-1:0] reset_vector_low,
    input wire logic internal_reset,
    input wire logic vector_fetch,
    input wire logic stop_mode,
    input wire logic watchdog_disable,
    input wire logic sys_reset_req,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe
);
    logic [19:0] since_q, since_d;
    logic [7:0] low_q, low_d;

    // Any event that empties the count restarts the lower bound on the next request.
    always_comb begin
        since_d = (since_q == 20'hFFFFF) ? since_q : since_q + 20'h00001;
        if ((bus_wr && bus_addr == WDT_ADDR_CLEAR) || internal_reset || vector_fetch || stop_mode || rst_pin_oe) begin
            since_d = 20'h00000;
        end
        low_d = rst_pin_oe ? low_q + 8'h01 : 8'h00;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            since_q <= 20'h00000;
            low_q <= 8'h00;
        end else begin
            since_q <= since_d;
            low_q <= low_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_REQ_NOT_EARLY: assert property (sys_reset_req |-> since_q >= TIMEOUT_CYCLES - 17)
        else $error("reset request came too soon after a clear");
    AST_PIN_LEN: assert property ($fell(rst_pin_oe) |-> low_q == PIN_LOW_CYCLES)
        else $error("reset pin low time has the wrong length");
    AST_PIN_MAX: assert property (rst_pin_oe |-> low_q < PIN_LOW_CYCLES)
        else $error("reset pin held low too long");
    AST_REQ_STARTS_PIN: assert property (sys_reset_req |-> rst_pin_oe && low_q == 8'h00)
        else $error("reset pin drive does not start with the request");
    AST_REQ_PULSE: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    AST_PIN_DRIVES_LOW: assert property (rst_pin_oe |-> !rst_pin_out)
        else $error("reset pin driven high");
    AST_READ_VECTOR: assert property (bus_rd && bus_addr == WDT_ADDR_CLEAR && !rst_pin_oe
        |=> bus_rdata == $past(reset_vector_low))
        else $error("clear address read did not return vector byte");
    AST_RDATA_IDLE: assert property (!bus_rd |=> bus_rdata == WDT_READ_ZERO)
        else $error("read data not zero outside a read");
    AST_DISABLED_QUIET: assert property (watchdog_disable && $past(watchdog_disable) |-> !sys_reset_req)
        else $error("reset request while disabled");

    COV_REQ: cover property (sys_reset_req);
    COV_PIN_END: cover property ($fell(rst_pin_oe));
    COV_DISABLED: cover property (watchdog_disable);
endmodule // wdt_reset_timer_monitor

bind wdt_reset_timer wdt_reset_timer_monitor #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .PIN_LOW_CYCLES(PIN_LOW_CYCLES)
) u_mon (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus_addr(bus_addr),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .reset_vector_low(reset_vector_low),
    .internal_reset(internal_reset),
    .vector_fetch(vector_fetch),
    .stop_mode(stop_mode),
    .watchdog_disable(watchdog_disable),
    .sys_reset_req(sys_reset_req),
    .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe)
);

// ---- sim/wdt_reset_timer_test.sv ----
// Self-checking testbench for the watchdog reset timer.
`timescale 1ns/100ps
module wdt_reset_timer_test
    import wdt_pkg::*;
;
    localparam int unsigned TMO = 200;
    localparam logic [7:0] VEC_LOW = 8'hA5;
    logic ref_clk, rst_n, bus_wr, bus_rd, internal_reset, vector_fetch, stop_mode, monitor_mode;
    logic irq_test_high_voltage, rst_test_high_voltage, watchdog_disable, sys_reset_req, rst_pin_oe, rst_pin_out;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    int cyc, req_cnt, num_checks, n_mismatch, i;

    wdt_reset_timer #(.TIMEOUT_CYCLES(TMO), .POR_CLEAR_CYCLES(8), .PIN_LOW_CYCLES(32)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .reset_vector_low(VEC_LOW), .internal_reset(internal_reset),
        .vector_fetch(vector_fetch), .stop_mode(stop_mode), .monitor_mode(monitor_mode),
        .irq_test_high_voltage(irq_test_high_voltage), .rst_test_high_voltage(rst_test_high_voltage),
        .watchdog_disable(watchdog_disable), .sys_reset_req(sys_reset_req),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // The request is a single-cycle pulse, so it is counted here rather than polled by the tasks.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (sys_reset_req === 1'b1) begin
            req_cnt <= req_cnt + 1;
        end
        if (cyc == 8000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        chk(what, 32'(bus_rdata & mask), 32'(exp));
    endtask

    task automatic expect_quiet(input int n);
        int c;
        c = req_cnt;
        repeat (n) @(posedge ref_clk);
        #1;
        chk("reset request count", req_cnt, c);
    endtask

    // Counting starts at n0 cycles already spent; the low nibble kept by a clear widens the window.
    task automatic expect_req(input string what, input int n0);
        int c, n, m;
        c = req_cnt;
        n = n0;
        m = 0;
        while (req_cnt == c && n < TMO + 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(what, 32'(n >= TMO - 35 && n <= TMO + 5), 32'h1);
        chk("reset pin level", 32'(rst_pin_out), 32'h0);
        while (rst_pin_oe === 1'b1 && m < 64) begin
            @(posedge ref_clk);
            #1;
            m++;
        end
        chk("reset pin low cycles", m, 31);
    endtask

    initial begin
        cyc = 0;
        req_cnt = 0;
        num_checks = 0;
        n_mismatch = 0;
        rst_n = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        internal_reset = 1'b0;
        vector_fetch = 1'b0;
        stop_mode = 1'b0;
        monitor_mode = 1'b0;
        irq_test_high_voltage = 1'b0;
        rst_test_high_voltage = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("disable after reset", watchdog_disable, 1'b0);
        rd_chk("vector byte", WDT_ADDR_CLEAR, 8'hFF, VEC_LOW);
        rd_chk("cause after power-on", WDT_ADDR_CAUSE, 8'h10, 8'h00);
        rd_chk("unmapped read", 16'h1234, 8'hFF, 8'h00);
        wr(16'h1234, 8'hFF);
        for (i = 0; i < 3; i++) begin
            wr(WDT_ADDR_CLEAR, 8'(i * 85));
            expect_quiet(150);
        end
        vector_fetch <= 1'b1;
        @(posedge ref_clk);
        vector_fetch <= 1'b0;
        expect_quiet(150);
        wr(WDT_ADDR_CLEAR, 8'h00);
        for (i = 0; i < 60; i++) begin
            rd_chk("vector byte while counting", WDT_ADDR_CLEAR, 8'hFF, VEC_LOW);
        end
        expect_req("timeout with reads", 120);
        rd_chk("cause after timeout", WDT_ADDR_CAUSE, 8'h10, 8'h10);
        wr(WDT_ADDR_CLEAR, 8'h00);
        stop_mode <= 1'b1;
        expect_quiet(400);
        stop_mode <= 1'b0;
        expect_req("timeout after stop", 0);
        for (i = 0; i < 2; i++) begin
            wr(WDT_ADDR_CLEAR, 8'h00);
            monitor_mode <= 1'b1;
            irq_test_high_voltage <= (i == 0);
            rst_test_high_voltage <= (i == 1);
            expect_quiet(400);
            irq_test_high_voltage <= 1'b0;
            rst_test_high_voltage <= 1'b0;
            wr(WDT_ADDR_CLEAR, 8'h00);
            expect_req("monitor without voltage", 0);
            monitor_mode <= 1'b0;
        end
        wr(WDT_ADDR_CONFIG, 8'h01);
        chk("disable set", watchdog_disable, 1'b1);
        expect_quiet(400);
        wr(WDT_ADDR_CONFIG, 8'h00);
        chk("disable write once", watchdog_disable, 1'b1);
        internal_reset <= 1'b1;
        @(posedge ref_clk);
        internal_reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("disable after internal reset", watchdog_disable, 1'b0);
        expect_req("timeout after internal reset", 1);
        give_verdict();
    end
endmodule // wdt_reset_timer_test
